/* File: asc_seq_ctrl.sv */
// Purpose: sequences conversions of the analog core and reacts to stop and freeze; wait is treated as run
// Assumes: all control inputs and the core handshake are on ref_clk
// Notes:   results leave through a two-entry buffer so a stalled consumer loses nothing
`timescale 1ns/1ps
module asc_seq_ctrl import asc_pkg::*; #(
  parameter int NCH   = ASC_NUM_CH,
  parameter int RES_W = ASC_RES_W
) (
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic                seqStartWrite,
  input  wire logic                multiChannelSel,
  input  wire logic                continuousSel,
  input  wire logic [ASC_CH_W-1:0] startChannel,
  input  wire logic [ASC_CH_W-1:0] seqLenMinus1,
  input  wire logic                stopMode,
  input  wire logic                waitMode,
  input  wire logic                freezeActive,
  input  wire logic                freezeModeSelHi,
  input  wire logic                freezeModeSelLo,
  output logic                     convStart,
  output logic                     convAbort,
  output logic      [ASC_CH_W-1:0] convChannel,
  input  wire logic                convDone,
  input  wire logic [RES_W-1:0]    convResult,
  output logic                     resValid,
  input  wire logic                resReady,
  output logic      [RES_W-1:0]    resData,
  output logic      [ASC_CH_W-1:0] resChannel,
  output logic      [NCH-1:0]      convFlags,
  output logic                     seqComplete,
  output logic                     seqBusy,
  output logic                     restartPending
);
  asc_state_t           state_r;
  asc_state_t           state_nxt;
  logic [ASC_CH_W-1:0]  idx_r;
  logic [RES_W-1:0]     result_r;
  logic [NCH-1:0]       flags_r;
  logic                 complete_r;
  logic                 pending_r;
  logic                 stopPrev_r;
  logic [1:0]           frzSel;
  logic                 frzHold;
  logic                 frzHalt;
  logic                 stopExit;
  logic                 freshStart;
  logic                 bufReady;
  logic                 pushNow;
  logic                 lastConv;

  assign frzSel   = {freezeModeSelHi, freezeModeSelLo};
  // finish and halt both keep new conversions from being issued while frozen
  assign frzHold  = freezeActive && (frzSel == ASC_FRZ_FINISH || frzSel == ASC_FRZ_HALT);
  assign frzHalt  = freezeActive && (frzSel == ASC_FRZ_HALT);
  assign stopExit = stopPrev_r && !stopMode && pending_r;
  // a restart after stop goes down the same path as a write to sequence_start_ctrl_reg
  assign freshStart = !stopMode && (seqStartWrite || stopExit);
  assign seqBusy  = (state_r != ASC_IDLE) && (state_r != ASC_STOPPED);
  assign pushNow  = (state_r == ASC_PUSH) && bufReady;
  assign lastConv = (idx_r == seqLenMinus1) || !multiChannelSel;

  // waitMode is deliberately unused: wait behaves exactly as run
  assign convStart   = (state_r == ASC_ISSUE) && !stopMode && !frzHold && !seqStartWrite;
  assign convChannel = multiChannelSel ? ASC_CH_W'(startChannel + idx_r) : startChannel;
  assign convAbort   = (state_r == ASC_CONV) &&
                       (stopMode || seqStartWrite || frzHalt);
  assign convFlags   = flags_r;
  assign seqComplete = complete_r;
  assign restartPending = pending_r;

  always_comb begin
    state_nxt = state_r;
    if (stopMode) begin
      if (seqBusy) state_nxt = ASC_STOPPED;
    end else if (freshStart) begin
      state_nxt = ASC_ISSUE;
    end else begin
      unique case (state_r)
        ASC_IDLE:    state_nxt = ASC_IDLE;
        ASC_ISSUE:   if (convStart) state_nxt = ASC_CONV;
        ASC_CONV: begin
          if (frzHalt) state_nxt = ASC_ISSUE;
          else if (convDone) state_nxt = ASC_PUSH;
        end
        ASC_PUSH: begin
          if (pushNow) begin
            if (lastConv && !continuousSel) state_nxt = ASC_IDLE;
            else state_nxt = ASC_ISSUE;
          end
        end
        ASC_STOPPED: state_nxt = pending_r ? ASC_STOPPED : ASC_IDLE;
        default:     state_nxt = ASC_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) state_r <= ASC_IDLE;
    else     state_r <= state_nxt;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stopPrev_r <= 1'b0;
      pending_r  <= 1'b0;
    end else begin
      stopPrev_r <= stopMode;
      if (stopMode && seqBusy) pending_r <= 1'b1;
      else if (stopMode && seqStartWrite) pending_r <= 1'b1;
      else if (!stopMode) pending_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      idx_r <= ASC_IDX_RST;
    end else if (freshStart) begin
      idx_r <= ASC_IDX_RST;
    end else if (pushNow) begin
      idx_r <= lastConv ? ASC_IDX_RST : idx_r + ASC_CH_W'(1);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) result_r <= '0;
    else if (state_r == ASC_CONV && convDone) result_r <= convResult;
  end

  // a start aborts the old sequence, so its last result never sets a flag of the new one
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flags_r    <= ASC_FLAGS_RST[NCH-1:0];
      complete_r <= 1'b0;
    end else if (freshStart) begin
      flags_r    <= ASC_FLAGS_RST[NCH-1:0];
      complete_r <= 1'b0;
    end else if (pushNow) begin
      flags_r[convChannel] <= 1'b1;
      if (lastConv) complete_r <= 1'b1;
    end
  end

  asc_pair_buf #(
    .WIDTH (RES_W + ASC_CH_W),
    .DEPTH (ASC_BUF_DEPTH)
  ) u_buf (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .inValid  (state_r == ASC_PUSH),
    .inReady  (bufReady),
    .inData   ({convChannel, result_r}),
    .outValid (resValid),
    .outReady (resReady),
    .outData  ({resChannel, resData})
  );

  // checks
  a_stop_abort: assert property (@(posedge ref_clk) disable iff (rst)
    stopMode && seqBusy |=> state_r == ASC_STOPPED && pending_r)
    else $error("stop did not abort the sequence");

  a_stop_restart: assert property (@(posedge ref_clk) disable iff (rst)
    stopPrev_r && !stopMode && pending_r |=> state_r == ASC_ISSUE ##1 !pending_r)
    else $error("aborted sequence not restarted after stop");

  a_pending_from_stop: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(pending_r) |-> $past(stopMode))
    else $error("restart pending set outside stop");

  a_restart_clear: assert property (@(posedge ref_clk) disable iff (rst)
    stopExit |=> flags_r == '0 && !complete_r && idx_r == ASC_IDX_RST)
    else $error("restart after stop left flags set");

  a_start_clear: assert property (@(posedge ref_clk) disable iff (rst)
    seqStartWrite && !stopMode |=> flags_r == '0 && state_r == ASC_ISSUE)
    else $error("start write did not restart the sequence");

  a_wait_ignored: assert property (@(posedge ref_clk) disable iff (rst)
    waitMode && state_r == ASC_ISSUE && !stopMode && !freezeActive && !seqStartWrite
    |-> convStart)
    else $error("wait mode held off a conversion");

  a_freeze_hold: assert property (@(posedge ref_clk) disable iff (rst)
    freezeActive && freezeModeSelHi |-> !convStart)
    else $error("conversion issued while frozen");

  a_freeze_halt: assert property (@(posedge ref_clk) disable iff (rst)
    frzHalt && state_r == ASC_CONV && !stopMode && !seqStartWrite
    |-> convAbort ##1 state_r == ASC_ISSUE)
    else $error("halting freeze did not stop the conversion");

  a_single_chan: assert property (@(posedge ref_clk) disable iff (rst)
    convStart && !multiChannelSel |-> convChannel == startChannel)
    else $error("single-channel mode moved off the start channel");

  a_flag_on_push: assert property (@(posedge ref_clk) disable iff (rst)
    pushNow && !stopMode && !freshStart |=> flags_r[$past(convChannel)])
    else $error("pushed result did not set its channel flag");

  a_single_end: assert property (@(posedge ref_clk) disable iff (rst)
    pushNow && lastConv && !continuousSel && !stopMode && !freshStart
    |=> state_r == ASC_IDLE && complete_r)
    else $error("single sequence did not end");

  c_seq_done:   cover property (@(posedge ref_clk) disable iff (rst)
    pushNow && lastConv && !continuousSel);
  c_stop_cycle: cover property (@(posedge ref_clk) disable iff (rst) stopExit);
  c_buf_full:   cover property (@(posedge ref_clk) disable iff (rst)
    state_r == ASC_PUSH && !bufReady);
  c_frz_halt:   cover property (@(posedge ref_clk) disable iff (rst)
    frzHalt && convAbort);
  c_start_abort: cover property (@(posedge ref_clk) disable iff (rst)
    seqStartWrite && convAbort);
endmodule : asc_seq_ctrl

/* File: asc_pkg.sv */
// Purpose: shared constants of the conversion sequence controller
// Assumes: up to 16 analog inputs, 12-bit conversion results
// Notes:   freeze selector is {freezeModeSelHi, freezeModeSelLo}
package asc_pkg;
  localparam int          ASC_NUM_CH      = 16;
  localparam int          ASC_CH_W        = 4;
  localparam int          ASC_RES_W       = 12;
  localparam int          ASC_BUF_DEPTH   = 2;
  localparam logic [1:0]  ASC_FRZ_CONT    = 2'h0;
  localparam logic [1:0]  ASC_FRZ_CONT_B  = 2'h1;
  localparam logic [1:0]  ASC_FRZ_FINISH  = 2'h2;
  localparam logic [1:0]  ASC_FRZ_HALT    = 2'h3;
  localparam logic [15:0] ASC_FLAGS_RST   = 16'h0000;
  localparam logic [3:0]  ASC_IDX_RST     = 4'h0;

  typedef enum logic [4:0] {
    ASC_IDLE    = 5'h01,
    ASC_ISSUE   = 5'h02,
    ASC_CONV    = 5'h04,
    ASC_PUSH    = 5'h08,
    ASC_STOPPED = 5'h10
  } asc_state_t;
endpackage : asc_pkg

/* File: asc_pair_buf.sv */
// Purpose: small valid/ready buffer between the sequencer and the result consumer
// Assumes: DEPTH is a power of two, at least 2
// Notes:   inReady is combinational from the fill count, outValid likewise
`timescale 1ns/1ps
module asc_pair_buf #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_r;
  logic [AW-1:0]    rdPtr_r;
  logic [AW:0]      count_r;
  logic             doPush;
  logic             doPop;

  assign inReady  = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;
  assign outData  = mem[rdPtr_r];

  always_ff @(posedge ref_clk) begin
    if (doPush) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (doPush) wrPtr_r <= wrPtr_r + AW'(1);
      if (doPop)  rdPtr_r <= rdPtr_r + AW'(1);
      count_r <= count_r + (AW+1)'(doPush) - (AW+1)'(doPop);
    end
  end
endmodule : asc_pair_buf

/* File: asc_core_model.sv */
// Purpose: behavioural analog conversion core facing the sequencer
// Assumes: one conversion at a time; latency in cycles set by lat
// Notes:   result word is {channel, 8'h5A}; idle data line toggles every cycle between the inverted and the true last word
`timescale 1ns/1ps
module asc_core_model import asc_pkg::*; (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic                 convStart,
  input  wire logic                 convAbort,
  input  wire logic [ASC_CH_W-1:0]  convChannel,
  input  wire logic [3:0]           lat,
  output logic                      convDone,
  output logic      [ASC_RES_W-1:0] convResult
);
  logic                busy_r;
  logic [3:0]          cnt_r;
  logic [ASC_CH_W-1:0] ch_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
      cnt_r <= 4'h0;
      ch_r <= 4'h0;
      convDone <= 1'b0;
      convResult <= 12'h000;
    end else begin
      convDone <= 1'b0;
      // result is only valid in the done cycle, so never leave it standing
      convResult <= ~convResult;
      if (convAbort) begin
        busy_r <= 1'b0;
      end else if (convStart) begin
        busy_r <= 1'b1;
        cnt_r <= lat;
        ch_r <= convChannel;
      end else if (busy_r && cnt_r == 4'h0) begin
        busy_r <= 1'b0;
        convDone <= 1'b1;
        convResult <= {ch_r, 8'h5A};
      end else if (busy_r) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
endmodule : asc_core_model

/* File: testbench.sv */
// Purpose: self-checking bench for the conversion sequence controller
// Assumes: core model answers lat+1 cycles after a start; consumer driven by getRes
// Notes:   continuous scenario runs last since it never drains on its own
`timescale 1ns/1ps
module testbench import asc_pkg::*;;
  logic ref_clk = 0, rst = 1, seqStartWrite = 0, multiChannelSel = 0, continuousSel = 0;
  logic stopMode = 0, waitMode = 0, freezeActive = 0, freezeModeSelHi = 0, freezeModeSelLo = 0;
  logic [3:0] startChannel = 0, seqLenMinus1 = 0, lat = 0, convChannel, resChannel;
  logic convStart, convAbort, convDone, resValid, resReady = 0, seqComplete, seqBusy;
  logic restartPending;
  logic [11:0] convResult, resData;
  logic [15:0] convFlags;
  int errors = 0, nChecks = 0, cyc = 0, nS, nA;

  asc_seq_ctrl asc_seq_ctrl_i (.ref_clk(ref_clk), .rst(rst), .seqStartWrite(seqStartWrite),
    .multiChannelSel(multiChannelSel), .continuousSel(continuousSel),
    .startChannel(startChannel), .seqLenMinus1(seqLenMinus1), .stopMode(stopMode),
    .waitMode(waitMode), .freezeActive(freezeActive), .freezeModeSelHi(freezeModeSelHi),
    .freezeModeSelLo(freezeModeSelLo), .convStart(convStart), .convAbort(convAbort),
    .convChannel(convChannel), .convDone(convDone), .convResult(convResult),
    .resValid(resValid), .resReady(resReady), .resData(resData), .resChannel(resChannel),
    .convFlags(convFlags), .seqComplete(seqComplete), .seqBusy(seqBusy),
    .restartPending(restartPending));
  asc_core_model asc_core_model_i (.ref_clk(ref_clk), .rst(rst), .convStart(convStart),
    .convAbort(convAbort), .convChannel(convChannel), .lat(lat), .convDone(convDone),
    .convResult(convResult));

  always #10 ref_clk = ~ref_clk;

  task automatic endSim;
    if (errors == 0 && nChecks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : endSim

  // a hang counts as a mismatch
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      endSim();
    end
  end

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic startSeq(logic multi, logic cont, logic [3:0] ch, logic [3:0] len);
    @(posedge ref_clk);
    multiChannelSel <= multi;
    continuousSel <= cont;
    startChannel <= ch;
    seqLenMinus1 <= len;
    seqStartWrite <= 1'b1;
    @(posedge ref_clk);
    seqStartWrite <= 1'b0;
  endtask : startSeq

  task automatic getRes(logic [3:0] ch);
    int i;
    i = 0;
    @(negedge ref_clk);
    while (resValid !== 1'b1 && i < 60) begin
      @(negedge ref_clk);
      i++;
    end
    check("resValid", resValid, 1'b1);
    check("resChannel", resChannel, ch);
    check("resData", resData, {ch, 8'h5A});
    @(posedge ref_clk);
    resReady <= 1'b1;
    @(posedge ref_clk);
    resReady <= 1'b0;
  endtask : getRes

  task automatic waitStart;
    int i;
    i = 0;
    @(negedge ref_clk);
    while (convStart !== 1'b1 && i < 40) begin
      @(negedge ref_clk);
      i++;
    end
    check("convStart", convStart, 1'b1);
  endtask : waitStart

  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    check("resValid reset", resValid, 1'b0);
    check("flags reset", convFlags, ASC_FLAGS_RST);
    // single sequence on the first analog input only, multi select cleared
    startSeq(1'b0, 1'b0, 4'h0, 4'h3);
    getRes(4'h0);
    check("flags single", convFlags, 16'h0001);
    check("complete", seqComplete, 1'b1);
    // receiver stalls: two words held, third result waits in push
    startSeq(1'b1, 1'b0, 4'h3, 4'h2);
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk);
    check("busy stalled", seqBusy, 1'b1);
    for (int c = 3; c <= 5; c++) getRes(c[3:0]);
    check("flags multi", convFlags, 16'h0038);
    check("idle", seqBusy, 1'b0);
    // start write in mid-conversion drops the old sequence
    lat <= 4'h6;
    startSeq(1'b1, 1'b0, 4'h2, 4'h2);
    waitStart();
    check("start chan", convChannel, 16'h0002);
    repeat (2) @(posedge ref_clk);
    startSeq(1'b0, 1'b0, 4'h9, 4'h0);
    getRes(4'h9);
    check("flags restart", convFlags, 16'h0200);
    // each freeze code while a conversion is outstanding
    lat <= 4'h4;
    for (int f = 0; f < 4; f++) begin
      startSeq(1'b1, 1'b0, 4'h1, 4'h1);
      waitStart();
      @(posedge ref_clk);
      {freezeModeSelHi, freezeModeSelLo} <= f[1:0];
      freezeActive <= 1'b1;
      nS = 0;
      nA = 0;
      repeat (12) begin
        @(negedge ref_clk);
        nS += convStart;
        nA += convAbort;
      end
      check("frz starts", nS[15:0], (f < 2) ? 16'h0001 : 16'h0000);
      check("frz abort", nA[15:0], (f == 3) ? 16'h0001 : 16'h0000);
      @(posedge ref_clk);
      freezeActive <= 1'b0;
      getRes(4'h1);
      getRes(4'h2);
      check("frz flags", convFlags, 16'h0006);
    end
    // continuous on one channel, wait mode on; conversions not aborted before stop
    lat <= 4'h2;
    waitMode <= 1'b1;
    startSeq(1'b0, 1'b1, 4'h7, 4'h0);
    getRes(4'h7);
    getRes(4'h7);
    check("flags wait", convFlags, 16'h0080);
    stopMode <= 1'b1;
    repeat (2) @(posedge ref_clk);
    resReady <= 1'b1;
    repeat (4) @(posedge ref_clk);
    resReady <= 1'b0;
    @(negedge ref_clk);
    check("pending", restartPending, 1'b1);
    check("no start", convStart, 1'b0);
    @(posedge ref_clk);
    stopMode <= 1'b0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    check("flags cleared", convFlags, 16'h0000);
    getRes(4'h7);
    check("flags again", convFlags, 16'h0080);
    check("pending off", restartPending, 1'b0);
    endSim();
  end
endmodule : testbench
